/* File: usart_pin_status_modem_interface_tb_top.sv */
// self-checking bench for the serial pin-status block
`timescale 1ns/1ps
`include "usps_consts.vh"
module usart_pin_status_modem_interface_tb_top;
    reg         ref_clk = 1'b0, reset_n = 1'b0, status_read = 1'b0;
    reg         transmitter_enable_bit = 1'b1, receiver_enable_bit = 1'b1;
    reg         command_bit_request_send = 1'b0, command_bit_terminal_ready = 1'b0;
    reg         tx_valid = 1'b0, rx_ready = 1'b0, clear_to_send_n = 1'b0;
    reg         carrier_detect_n = 1'b1, data_set_ready_n = 1'b1;
    reg         tx_clock_internal = 1'b0, rx_clock_internal = 1'b0;
    reg         baud_reference_clock = 1'b0;
    wire        transmit_bit_clock_out, transmit_bit_clock_oe;
    wire        receive_bit_clock_out, receive_bit_clock_oe;
    reg  [7:0]  tx_data = 8'h00, b, m;
    reg  [7:0]  q[$];
    wire [7:0]  rx_data, status_bits;
    wire        tx_ready, rx_valid, txd, rxd, bit_clk, request_to_send_n;
    wire        data_terminal_ready_n, receive_char_available_n;
    wire        transmit_holding_free_n, tx_idle_or_line_change_n;
    wire [11:0] tx_hist;
    wire [7:0]  pins = {receive_char_available_n, transmit_holding_free_n,
        tx_idle_or_line_change_n, txd, request_to_send_n, data_terminal_ready_n,
        rx_valid, tx_ready};
    integer     n_mismatch = 0, n_compared = 0, seed = 32'hE362, i;
    // reference only runs while the internal clock is selected
    usps_top u_dut (.*, .clock_factor(`USPS_FACTOR_1X),
        .baud_half_count(`USPS_BAUD_HALF_DEFAULT), .transmit_bit_clock_in(bit_clk),
        .receive_bit_clock_in(bit_clk));
    usps_modem u_modem (.txd(txd), .bit_clk(bit_clk), .rxd(rxd), .tx_hist(tx_hist));
    // ********************************
    // helpers
    // ********************************
    always #12.5 ref_clk = ~ref_clk;
    task cyc(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task sread;
        begin
            status_read = 1'b1;
            cyc(1);
            status_read = 1'b0;
            cyc(1);
        end
    endtask
    task pop;
        begin
            chk(rx_data, q.pop_front());
            rx_ready = 1'b1;
            cyc(1);
            rx_ready = 1'b0;
            cyc(1);
        end
    endtask
    task report_and_stop;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // ********************************
    // scenarios
    // ********************************
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        chk(pins, 8'hBD);
        chk(status_bits, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            b = $random(seed);
            {command_bit_request_send, command_bit_terminal_ready} = b[1:0];
            cyc(1);
            chk(pins & 8'h0C, {4'h0, ~b[1:0], 2'h0});
        end
        $display("reset and modem outputs done");
        // set-ready then carrier go active; each flags one change
        for (i = 0; i < 2; i = i + 1) begin
            data_set_ready_n = 1'b0;
            carrier_detect_n = (i == 0);
            m = 8'h04 | (8'h80 >> i);
            cyc(4);
            chk(status_bits & m, m);
            sread;
            chk(pins & 8'h20, 8'h20);
        end
        $display("line change done");
        // three frames unread: third overruns the two-entry buffer
        for (i = 0; i < 3; i = i + 1) begin
            tx_data = $random(seed);
            tx_valid = 1'b1;
            cyc(1);
            tx_valid = 1'b0;
            chk(pins & 8'h61, 8'h60);
            b = $random(seed);
            if (i < 2)
                q.push_back(b);
            u_modem.frame(b);
            cyc(1);
            chk(tx_hist[8:1], tx_data);
            chk({6'h00, tx_hist[9], tx_hist[0]}, 8'h02);
            chk(status_bits & 8'h10, (i == 2) ? 8'h10 : 8'h00);
            sread;
            chk(pins & 8'hA3, 8'h03);
        end
        chk(status_bits & 8'hD2, 8'hC2);
        pop;
        chk(pins & 8'h82, 8'h02);
        chk(rx_data, q.pop_front());
        receiver_enable_bit = 1'b0;
        transmitter_enable_bit = 1'b0;
        cyc(3);
        chk(pins & 8'h92, 8'h90);
        $display("transfer and buffer done");
        // internal 1X clock toggles after half count plus one reference rises
        tx_clock_internal = 1'b1;
        rx_clock_internal = 1'b1;
        m = {7'h00, transmit_bit_clock_out};
        for (i = 0; i < 2 * `USPS_BAUD_HALF_DEFAULT; i = i + 1) begin
            baud_reference_clock = ~baud_reference_clock;
            cyc(1);
        end
        cyc(3);
        chk({6'h00, transmit_bit_clock_out, transmit_bit_clock_oe}, {6'h00, m[0], 1'b1});
        baud_reference_clock = 1'b1;
        cyc(4);
        chk({6'h00, receive_bit_clock_out, receive_bit_clock_oe}, {6'h00, ~m[0], 1'b1});
        chk({7'h00, transmit_bit_clock_out}, {7'h00, ~m[0]});
        $display("internal clock done");
        report_and_stop;
    end
endmodule

/* File: usps_buf2.v */
// two-entry valid/ready buffer with flush
`timescale 1ns/1ps
module usps_buf2 #(
    parameter WIDTH = 8
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg             wr_ptr_reg;
    reg             rd_ptr_reg;
    reg [1:0]       count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_reg[0] <= {WIDTH{1'b0}};
            mem_reg[1] <= {WIDTH{1'b0}};
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else if (flush) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule

/* File: usps_consts.vh */
// constants shared by the serial pin-status block
`ifndef USPS_CONSTS_VH
`define USPS_CONSTS_VH

// ********************************************************
// clocking
// ********************************************************
`define USPS_REF_CLK_HZ        40000000
`define USPS_BAUD_REF_HZ       5068800
`define USPS_BAUD_HALF_DEFAULT 12'h042
`define USPS_SYNC_STAGES       2

// ********************************************************
// clock factor select
// ********************************************************
`define USPS_FACTOR_1X         2'h1
`define USPS_FACTOR_16X        2'h2
`define USPS_FACTOR_64X        2'h3
`define USPS_TICKS_1X          7'h01
`define USPS_TICKS_16X         7'h10
`define USPS_TICKS_64X         7'h40

// ********************************************************
// character format and status bit positions
// ********************************************************
`define USPS_DATA_BITS         8
`define USPS_SR_TX_FREE        0
`define USPS_SR_RX_AVAIL       1
`define USPS_SR_TX_IDLE_CHANGE 2
`define USPS_SR_OVERRUN        4
`define USPS_SR_FRAMING        5
`define USPS_SR_CARRIER        6
`define USPS_SR_SET_READY      7
`define USPS_SYNC_RESET        7'h7F
`define USPS_MARK              1'b1

`endif

/* File: usps_modem.sv */
// modem model: shared bit clock, receive frames, transmit capture
`timescale 1ns/1ps
module usps_modem (
    input  wire        txd,
    output reg         bit_clk,
    output reg         rxd,
    output reg  [11:0] tx_hist
);
    // ********************************
    // frame driver
    // ********************************
    initial begin
        bit_clk = 1'b1;
        rxd = 1'b1;
        tx_hist = 12'h000;
    end
    // clock stands high between frames; idle, start, data lsb first, stop, idle
    task frame(input [7:0] d);
        reg [11:0] bits;
        integer    k;
        begin
            bits = {2'h3, d, 2'h1};
            for (k = 0; k < 12; k = k + 1) begin
                bit_clk = 1'b0;
                rxd = bits[k];
                #100;
                bit_clk = 1'b1;
                tx_hist = {txd, tx_hist[11:1]};
                #100;
            end
        end
    endtask
endmodule

/* File: usps_sync.v */
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module usps_sync #(
    parameter             WIDTH    = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] stable_reg;

    // first stage feeds only the second stage
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg   <= RESET_VAL;
            stable_reg <= RESET_VAL;
        end else begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;
endmodule

/* File: usps_top.v */
// serial receiver-transmitter pin, modem and status logic
`timescale 1ns/1ps
`include "usps_consts.vh"
module usps_top (
    input  wire       ref_clk,
    input  wire       reset_n,
    input  wire       tx_clock_internal,
    input  wire       rx_clock_internal,
    input  wire [1:0] clock_factor,
    input  wire [11:0] baud_half_count,
    input  wire       transmitter_enable_bit,
    input  wire       receiver_enable_bit,
    input  wire       command_bit_request_send,
    input  wire       command_bit_terminal_ready,
    input  wire       tx_valid,
    output wire       tx_ready,
    input  wire [7:0] tx_data,
    output wire       rx_valid,
    input  wire       rx_ready,
    output wire [7:0] rx_data,
    input  wire       status_read,
    output wire [7:0] status_bits,
    input  wire       baud_reference_clock,
    input  wire       rxd,
    output wire       txd,
    input  wire       transmit_bit_clock_in,
    output wire       transmit_bit_clock_out,
    output wire       transmit_bit_clock_oe,
    input  wire       receive_bit_clock_in,
    output wire       receive_bit_clock_out,
    output wire       receive_bit_clock_oe,
    input  wire       carrier_detect_n,
    input  wire       clear_to_send_n,
    input  wire       data_set_ready_n,
    output wire       request_to_send_n,
    output wire       data_terminal_ready_n,
    output wire       receive_char_available_n,
    output wire       transmit_holding_free_n,
    output wire       tx_idle_or_line_change_n
);
    // ********************************************************
    // state encodings
    // ********************************************************
    localparam [3:0] RX_IDLE  = 4'h1;
    localparam [3:0] RX_START = 4'h2;
    localparam [3:0] RX_DATA  = 4'h4;
    localparam [3:0] RX_STOP  = 4'h8;
    localparam [3:0] TX_IDLE  = 4'h1;
    localparam [3:0] TX_START = 4'h2;
    localparam [3:0] TX_DATA  = 4'h4;
    localparam [3:0] TX_STOP  = 4'h8;

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    wire [6:0] pins_sync;
    wire       rxd_s;
    wire       txc_s;
    wire       rxc_s;
    wire       dcd_s;
    wire       cts_s;
    wire       dsr_s;
    wire       bref_s;

    usps_sync #(
        .WIDTH     (7),
        .RESET_VAL (`USPS_SYNC_RESET)
    ) u_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in ({baud_reference_clock, data_set_ready_n, clear_to_send_n,
                    carrier_detect_n, receive_bit_clock_in, transmit_bit_clock_in, rxd}),
        .sync_out (pins_sync)
    );

    assign {bref_s, dsr_s, cts_s, dcd_s, rxc_s, txc_s, rxd_s} = pins_sync;

    // ********************************************************
    // internal baud generator
    // ********************************************************
    reg [11:0] baud_cnt_reg;
    reg        bref_prev_reg;
    reg        int_clk_reg;

    // reference at 5.0688 MHz is well under half the 40 MHz sampling clock
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_cnt_reg  <= 12'h000;
            bref_prev_reg <= 1'b1;
            int_clk_reg   <= 1'b1;
        end else begin
            bref_prev_reg <= bref_s;
            if (bref_s && !bref_prev_reg) begin
                if (baud_cnt_reg >= baud_half_count) begin
                    baud_cnt_reg <= 12'h000;
                    int_clk_reg  <= ~int_clk_reg;
                end else begin
                    baud_cnt_reg <= baud_cnt_reg + 12'h001;
                end
            end
        end
    end

    assign transmit_bit_clock_out = int_clk_reg;
    assign transmit_bit_clock_oe  = tx_clock_internal;
    assign receive_bit_clock_out  = int_clk_reg;
    assign receive_bit_clock_oe   = rx_clock_internal;

    // ********************************************************
    // clock edges and factor
    // ********************************************************
    reg  [6:0] ext_ticks;
    wire [6:0] tx_ticks;
    wire [6:0] rx_ticks;
    wire       tx_clk_lvl;
    wire       rx_clk_lvl;
    reg        tx_clk_prev_reg;
    reg        rx_clk_prev_reg;
    wire       tx_fall;
    wire       rx_rise;

    always @* begin
        case (clock_factor)
            `USPS_FACTOR_16X: ext_ticks = `USPS_TICKS_16X;
            `USPS_FACTOR_64X: ext_ticks = `USPS_TICKS_64X;
            default:          ext_ticks = `USPS_TICKS_1X;
        endcase
    end

    assign tx_ticks   = tx_clock_internal ? `USPS_TICKS_1X : ext_ticks;
    assign rx_ticks   = rx_clock_internal ? `USPS_TICKS_1X : ext_ticks;
    assign tx_clk_lvl = tx_clock_internal ? int_clk_reg : txc_s;
    assign rx_clk_lvl = rx_clock_internal ? int_clk_reg : rxc_s;
    assign tx_fall    = tx_clk_prev_reg && !tx_clk_lvl;
    assign rx_rise    = !rx_clk_prev_reg && rx_clk_lvl;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_clk_prev_reg <= 1'b1;
            rx_clk_prev_reg <= 1'b1;
        end else begin
            tx_clk_prev_reg <= tx_clk_lvl;
            rx_clk_prev_reg <= rx_clk_lvl;
        end
    end

    // ********************************************************
    // receiver
    // ********************************************************
    reg  [3:0] rx_state_reg;
    reg  [6:0] rx_tick_reg;
    reg  [2:0] rx_bit_reg;
    reg  [7:0] rx_shift_reg;
    reg        rx_prev_data_reg;
    reg        rx_push_reg;
    reg        rx_frame_err_reg;
    wire       rx_run;
    wire       rx_in_ready;
    wire       rx_flush;

    // receiver only with carrier low and enabled
    assign rx_run   = receiver_enable_bit && !dcd_s;
    assign rx_flush = !rx_run;

    // sample on rising receive clock, mark high
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_reg     <= RX_IDLE;
            rx_tick_reg      <= 7'h00;
            rx_bit_reg       <= 3'h0;
            rx_shift_reg     <= 8'h00;
            rx_prev_data_reg <= `USPS_MARK;
            rx_push_reg      <= 1'b0;
            rx_frame_err_reg <= 1'b0;
        end else begin
            rx_push_reg <= 1'b0;
            if (!rx_run) begin
                rx_state_reg     <= RX_IDLE;
                rx_prev_data_reg <= `USPS_MARK;
            end else if (rx_rise) begin
                rx_prev_data_reg <= rxd_s;
                case (rx_state_reg)
                    RX_IDLE: begin
                        // a break must return to mark before the next start
                        if (rx_prev_data_reg && !rxd_s) begin
                            rx_tick_reg  <= 7'h00;
                            rx_state_reg <= (rx_ticks == `USPS_TICKS_1X) ? RX_DATA : RX_START;
                            rx_bit_reg   <= 3'h0;
                        end
                    end
                    RX_START: begin
                        if (rx_tick_reg == ((rx_ticks >> 1) - 7'h01)) begin
                            rx_tick_reg  <= 7'h00;
                            rx_state_reg <= rxd_s ? RX_IDLE : RX_DATA;
                        end else begin
                            rx_tick_reg <= rx_tick_reg + 7'h01;
                        end
                    end
                    RX_DATA: begin
                        if (rx_tick_reg == rx_ticks - 7'h01) begin
                            rx_tick_reg  <= 7'h00;
                            rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
                            rx_bit_reg   <= rx_bit_reg + 3'h1;
                            if (rx_bit_reg == 3'h7) begin
                                rx_state_reg <= RX_STOP;
                            end
                        end else begin
                            rx_tick_reg <= rx_tick_reg + 7'h01;
                        end
                    end
                    RX_STOP: begin
                        if (rx_tick_reg == rx_ticks - 7'h01) begin
                            rx_tick_reg      <= 7'h00;
                            rx_push_reg      <= 1'b1;
                            rx_frame_err_reg <= !rxd_s;
                            rx_state_reg     <= RX_IDLE;
                        end else begin
                            rx_tick_reg <= rx_tick_reg + 7'h01;
                        end
                    end
                    default: rx_state_reg <= RX_IDLE;
                endcase
            end
        end
    end

    // assembled character enters the holding buffer
    usps_buf2 #(
        .WIDTH (8)
    ) u_rx_hold (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .flush     (rx_flush),
        .in_valid  (rx_push_reg),
        .in_ready  (rx_in_ready),
        .in_data   (rx_shift_reg),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ********************************************************
    // transmitter
    // ********************************************************
    reg  [3:0] tx_state_reg;
    reg  [6:0] tx_tick_reg;
    reg  [2:0] tx_bit_reg;
    reg  [7:0] thr_reg;
    reg        thr_full_reg;
    reg  [7:0] tx_shift_reg;
    reg        txd_reg;
    reg        tx_empty_reg;
    wire       tx_step;
    wire       tx_load;
    wire       tx_take;

    assign tx_step  = tx_fall && (tx_tick_reg == tx_ticks - 7'h01);
    // new characters start only with clear-to-send low
    assign tx_take  = tx_step && (tx_state_reg == TX_IDLE) && thr_full_reg && !cts_s;
    assign tx_ready = !thr_full_reg;
    assign tx_load  = tx_valid && tx_ready;

    // reset aborts the character and parks the line at mark
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_reg <= TX_IDLE;
            tx_tick_reg  <= 7'h00;
            tx_bit_reg   <= 3'h0;
            thr_reg      <= 8'h00;
            thr_full_reg <= 1'b0;
            tx_shift_reg <= 8'h00;
            txd_reg      <= `USPS_MARK;
            tx_empty_reg <= 1'b0;
        end else begin
            // loading a character fills the holding register
            if (tx_load) begin
                thr_reg      <= tx_data;
                thr_full_reg <= 1'b1;
            end else if (tx_take) begin
                thr_full_reg <= 1'b0;
            end
            if (tx_fall) begin
                tx_tick_reg <= tx_step ? 7'h00 : tx_tick_reg + 7'h01;
            end
            if (!transmitter_enable_bit) begin
                tx_state_reg <= TX_IDLE;
                txd_reg      <= `USPS_MARK;
            end else if (tx_step) begin
                // data changes only at a falling-edge step
                case (tx_state_reg)
                    TX_IDLE: begin
                        if (tx_take) begin
                            tx_shift_reg <= thr_reg;
                            txd_reg      <= 1'b0;
                            tx_state_reg <= TX_START;
                        end
                    end
                    TX_START: begin
                        txd_reg      <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg   <= 3'h0;
                        tx_state_reg <= TX_DATA;
                    end
                    TX_DATA: begin
                        tx_bit_reg <= tx_bit_reg + 3'h1;
                        if (tx_bit_reg == 3'h7) begin
                            txd_reg      <= `USPS_MARK;
                            tx_state_reg <= TX_STOP;
                        end else begin
                            txd_reg      <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        end
                    end
                    TX_STOP: begin
                        tx_state_reg <= TX_IDLE;
                    end
                    default: tx_state_reg <= TX_IDLE;
                endcase
            end
            // drained flag sets at stop end, only a load clears it
            if (tx_enable_stop_done(tx_step, tx_state_reg, thr_full_reg, tx_load)) begin
                tx_empty_reg <= 1'b1;
            end else if (tx_load) begin
                tx_empty_reg <= 1'b0;
            end
        end
    end

    // drained means the stop bit ended with nothing waiting or arriving
    function tx_enable_stop_done;
        input       step;
        input [3:0] state;
        input       full;
        input       load;
        begin
            tx_enable_stop_done = step && (state == TX_STOP) && !full && !load;
        end
    endfunction

    assign txd = txd_reg;

    // ********************************************************
    // modem change detect and status
    // ********************************************************
    reg dcd_prev_reg;
    reg dsr_prev_reg;
    reg line_change_reg;
    reg overrun_reg;
    reg frame_err_reg;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dcd_prev_reg    <= 1'b1;
            dsr_prev_reg    <= 1'b1;
            line_change_reg <= 1'b0;
            overrun_reg     <= 1'b0;
            frame_err_reg   <= 1'b0;
        end else begin
            dcd_prev_reg <= dcd_s;
            dsr_prev_reg <= dsr_s;
            // a carrier or set-ready change flags; set wins over a status read
            if ((dcd_s != dcd_prev_reg) || (dsr_s != dsr_prev_reg)) begin
                line_change_reg <= 1'b1;
            end else if (status_read) begin
                line_change_reg <= 1'b0;
            end
            // full holding buffer cannot take the character
            if (rx_push_reg && !rx_in_ready) begin
                overrun_reg <= 1'b1;
            end else if (status_read) begin
                overrun_reg <= 1'b0;
            end
            if (rx_push_reg && rx_in_ready) begin
                frame_err_reg <= rx_frame_err_reg;
            end else if (status_read) begin
                frame_err_reg <= 1'b0;
            end
        end
    end

    assign status_bits[`USPS_SR_TX_FREE]        = !thr_full_reg;
    assign status_bits[`USPS_SR_RX_AVAIL]       = rx_valid;
    assign status_bits[`USPS_SR_TX_IDLE_CHANGE] = tx_empty_reg || line_change_reg;
    assign status_bits[3]                       = 1'b0;
    assign status_bits[`USPS_SR_OVERRUN]        = overrun_reg;
    assign status_bits[`USPS_SR_FRAMING]        = frame_err_reg;
    assign status_bits[`USPS_SR_CARRIER]        = !dcd_s;
    assign status_bits[`USPS_SR_SET_READY]      = !dsr_s;

    // ********************************************************
    // status pins
    // ********************************************************
    // receive-ready follows the buffer, flushed when disabled
    assign receive_char_available_n = !status_bits[`USPS_SR_RX_AVAIL];
    // transmit-ready follows the free holding register
    assign transmit_holding_free_n  = !status_bits[`USPS_SR_TX_FREE];
    assign tx_idle_or_line_change_n = !status_bits[`USPS_SR_TX_IDLE_CHANGE];
    assign request_to_send_n        = !command_bit_request_send;
    assign data_terminal_ready_n    = !command_bit_terminal_ready;
endmodule

/* File: usps_top_asserts.sv */
// concurrent checks on the pin, modem and status outputs
`timescale 1ns/1ps
module usps_top_asserts (
    input wire       ref_clk,
    input wire       reset_n,
    input wire       transmitter_enable_bit,
    input wire       receiver_enable_bit,
    input wire       command_bit_request_send,
    input wire       command_bit_terminal_ready,
    input wire       tx_valid,
    input wire       tx_ready,
    input wire [7:0] status_bits,
    input wire       txd,
    input wire       carrier_detect_n,
    input wire       request_to_send_n,
    input wire       data_terminal_ready_n,
    input wire       receive_char_available_n,
    input wire       transmit_holding_free_n,
    input wire       tx_idle_or_line_change_n
);
    // ********************************
    // pin relations
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_load;
        tx_valid && tx_ready;
    endsequence
    sequence s_taken;
        !tx_ready && transmit_holding_free_n;
    endsequence
    a_rx_pin_mirror: assert property (receive_char_available_n == !status_bits[1])
        else $error("receive pin differs from status");
    a_tx_free_mirror: assert property (transmit_holding_free_n == !status_bits[0])
        else $error("transmit pin differs from status");
    a_idle_pin_mirror: assert property (tx_idle_or_line_change_n == !status_bits[2])
        else $error("idle pin differs from status");
    a_load_takes_ready: assert property (s_load |=> s_taken)
        else $error("load left holding register free");
    a_disabled_mark: assert property (!transmitter_enable_bit |=> txd)
        else $error("line not at mark while disabled");
    a_rx_flush_off: assert property (!receiver_enable_bit |-> ##[1:3] receive_char_available_n)
        else $error("receive pin low after disable");
    // sync delay of two edges on the pin
    a_carrier_status: assert property (status_bits[6] == !$past(carrier_detect_n, 2))
        else $error("carrier status bit wrong");
    a_carrier_change: assert property ($rose(status_bits[6]) |-> ##[0:2] !tx_idle_or_line_change_n)
        else $error("carrier change not flagged");
    a_rts_inverse: assert property (request_to_send_n == !command_bit_request_send)
        else $error("request pin not inverse");
    a_dtr_inverse: assert property (data_terminal_ready_n == !command_bit_terminal_ready)
        else $error("terminal pin not inverse");
endmodule
bind usps_top usps_top_asserts u_chk (.*);
